//--- core/ptm_pkg.sv
/*
  Package for the period timer mode control block: register offsets, field
  positions, reset values, reset source codes and the state record.
  Assumes a single 25 MHz system clock and an AHB-Lite register bus.
*/
package ptm_pkg;
  localparam logic [7:0] PTM_OFS_COUNT = 8'h00;
  localparam logic [7:0] PTM_OFS_PERIOD = 8'h04;
  localparam logic [7:0] PTM_OFS_CONTROL = 8'h08;
  localparam logic [7:0] PTM_OFS_LIMIT = 8'h0C;
  localparam logic [7:0] PTM_OFS_RESET_SOURCE_FIELD = 8'h10;
  localparam logic [7:0] PTM_OFS_IRQ = 8'h14;

  localparam int PTM_CTRL_ON_BIT = 7;
  localparam int PTM_IRQ_FLAG_BIT = 0;
  localparam int PTM_IRQ_EN_BIT = 1;

  localparam logic [7:0] PTM_RST_COUNT = 8'h00;
  localparam logic [7:0] PTM_RST_PERIOD = 8'hFF;

  localparam logic [1:0] PTM_GRP_FREE = 2'h0;
  localparam logic [1:0] PTM_GRP_ONESHOT = 2'h1;
  localparam logic [1:0] PTM_GRP_MONO = 2'h2;
  localparam logic [1:0] PTM_GRP_RSVD = 2'h3;

  localparam logic [3:0] PTM_SRC_PIN = 4'h0;
  localparam logic [3:0] PTM_SRC_SIB0 = 4'h1;
  localparam logic [3:0] PTM_SRC_SIB1 = 4'h2;
  localparam logic [3:0] PTM_SRC_SIB2 = 4'h3;
  localparam logic [3:0] PTM_SRC_CCA = 4'h4;
  localparam logic [3:0] PTM_SRC_CCB = 4'h5;
  localparam logic [3:0] PTM_SRC_PWMA = 4'h6;
  localparam logic [3:0] PTM_SRC_PWMB = 4'h7;
  localparam logic [3:0] PTM_SRC_CMPA = 4'h8;
  localparam logic [3:0] PTM_SRC_CMPB = 4'h9;
  localparam logic [3:0] PTM_SRC_ZC = 4'hA;

  typedef struct packed {
    logic input_pin_route;
    logic [2:0] sibling_pulse;
    logic capture_compare_a_out;
    logic capture_compare_b_out;
    logic pwm_a_out;
    logic pwm_b_out;
    logic comparator_a_out;
    logic comparator_b_out;
    logic zero_cross_out;
  } ptm_src_t;

  typedef struct packed {
    logic [7:0] count_value;
    logic [7:0] period_value;
    logic on;
    logic [3:0] postscale_select;
    logic [4:0] mode;
    logic [3:0] reset_source_field;
    logic irq_flag;
    logic period_irq_enable;
    logic [3:0] post_cnt;
    logic ers_prev;
    logic started;
    logic pulse;
    logic irq;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic src_fresh;
  } ptm_state_t;
endpackage

//--- core/ptm_timer.sv
/*
  Mode, output, external reset and interrupt logic of an 8-bit period timer
  with an AHB-Lite register slave. Assumes timer_tick is a one-cycle strobe
  from the prescaler, synchronous to clk, and that all trigger sources are
  synchronous to clk.
*/
`timescale 1ns/1ns
module ptm_timer #(
  parameter int INST_IDX = 0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic timer_tick,
  input wire logic debug_mode,
  input wire ptm_pkg::ptm_src_t src,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic postscaled_pulse_out,
  output logic irq_out
);
  ptm_pkg::ptm_state_t s_r;
  ptm_pkg::ptm_state_t s_nxt;
  logic ers_raw;
  logic ers;
  logic rise;
  logic fall;
  logic anye;
  logic cnt_on;
  logic hw_rst;
  logic start_evt;
  logic oneshot;
  logic mono;
  logic flag_set;
  logic acc;
  logic [1:0] grp;
  logic [2:0] var_sel;
  logic [2:0] sib_ok;

  // A timer never triggers from its own postscaled pulse
  for (genvar k = 0; k < 3; k++) begin : g_sib
    assign sib_ok[k] = (INST_IDX != k) & src.sibling_pulse[k];
  end

  always_comb begin
    s_nxt = s_r;
    grp = s_r.mode[4:3];
    var_sel = s_r.mode[2:0];
    ers_raw = 1'b0;
    unique case (s_r.reset_source_field)
      ptm_pkg::PTM_SRC_PIN: ers_raw = src.input_pin_route;
      ptm_pkg::PTM_SRC_SIB0: ers_raw = sib_ok[0];
      ptm_pkg::PTM_SRC_SIB1: ers_raw = sib_ok[1];
      ptm_pkg::PTM_SRC_SIB2: ers_raw = sib_ok[2];
      ptm_pkg::PTM_SRC_CCA: ers_raw = src.capture_compare_a_out;
      ptm_pkg::PTM_SRC_CCB: ers_raw = src.capture_compare_b_out;
      ptm_pkg::PTM_SRC_PWMA: ers_raw = src.pwm_a_out;
      ptm_pkg::PTM_SRC_PWMB: ers_raw = src.pwm_b_out;
      ptm_pkg::PTM_SRC_CMPA: ers_raw = src.comparator_a_out;
      ptm_pkg::PTM_SRC_CMPB: ers_raw = src.comparator_b_out;
      ptm_pkg::PTM_SRC_ZC: ers_raw = src.zero_cross_out;
      default: ers_raw = 1'b0;
    endcase
    // Freezing the level hides any edge while debugging
    ers = debug_mode ? s_r.ers_prev : ers_raw;
    // After a new source or mode the old sample is meaningless; skip one edge check
    rise = ers & ~s_r.ers_prev & ~s_r.src_fresh;
    fall = ~ers & s_r.ers_prev & ~s_r.src_fresh;
    anye = rise | fall;
    cnt_on = 1'b0;
    hw_rst = 1'b0;
    start_evt = 1'b0;
    oneshot = 1'b0;
    mono = 1'b0;
    flag_set = 1'b0;
    unique case (grp)
      ptm_pkg::PTM_GRP_FREE: begin
        unique case (var_sel)
          3'h0: cnt_on = s_r.on;
          3'h1: cnt_on = s_r.on & ers;
          3'h2: cnt_on = s_r.on & ~ers;
          3'h3: begin
            cnt_on = s_r.on;
            hw_rst = s_r.on & anye;
          end
          3'h4: begin
            cnt_on = s_r.on;
            hw_rst = s_r.on & rise;
          end
          3'h5: begin
            cnt_on = s_r.on;
            hw_rst = s_r.on & fall;
          end
          3'h6: begin
            cnt_on = s_r.on;
            hw_rst = s_r.on & ~ers;
          end
          3'h7: begin
            cnt_on = s_r.on;
            hw_rst = s_r.on & ers;
          end
        endcase
      end
      ptm_pkg::PTM_GRP_ONESHOT: begin
        oneshot = 1'b1;
        unique case (var_sel)
          3'h0: start_evt = 1'b1;
          3'h1: start_evt = rise;
          3'h2: start_evt = fall;
          3'h3: start_evt = anye;
          3'h4: begin
            start_evt = rise;
            hw_rst = s_r.on & s_r.started & rise;
          end
          3'h5: begin
            start_evt = fall;
            hw_rst = s_r.on & s_r.started & fall;
          end
          3'h6: begin
            start_evt = rise;
            hw_rst = s_r.on & s_r.started & ~ers;
          end
          3'h7: begin
            start_evt = fall;
            hw_rst = s_r.on & s_r.started & ers;
          end
        endcase
        cnt_on = s_r.on & s_r.started;
      end
      ptm_pkg::PTM_GRP_MONO: begin
        unique case (var_sel)
          3'h1, 3'h2, 3'h3: begin
            mono = 1'b1;
            start_evt = (var_sel == 3'h1) ? rise : ((var_sel == 3'h2) ? fall : anye);
            cnt_on = s_r.on & s_r.started;
          end
          3'h6: begin
            oneshot = 1'b1;
            cnt_on = s_r.on & ers;
            hw_rst = s_r.on & ~ers;
          end
          3'h7: begin
            oneshot = 1'b1;
            cnt_on = s_r.on & ~ers;
            hw_rst = s_r.on & ers;
          end
          default: cnt_on = 1'b0;
        endcase
      end
      ptm_pkg::PTM_GRP_RSVD: cnt_on = 1'b0;
    endcase

    if (timer_tick) begin
      s_nxt.ers_prev = ers;
      s_nxt.src_fresh = 1'b0;
      s_nxt.pulse = 1'b0;
      // Clearing started on off forces a fresh start event after on returns
      if (!s_r.on) begin
        s_nxt.started = 1'b0;
      end else if (start_evt) begin
        s_nxt.started = 1'b1;
      end
      if (hw_rst) begin
        s_nxt.count_value = ptm_pkg::PTM_RST_COUNT;
        s_nxt.post_cnt = 4'h0;
      end else if (cnt_on) begin
        if (s_r.count_value == s_r.period_value) begin
          s_nxt.count_value = ptm_pkg::PTM_RST_COUNT;
          if (oneshot) begin
            s_nxt.on = 1'b0;
            s_nxt.started = 1'b0;
            s_nxt.post_cnt = 4'h0;
            s_nxt.pulse = 1'b1;
            flag_set = 1'b1;
          end else begin
            if (mono) begin
              s_nxt.started = 1'b0;
            end
            if (s_r.post_cnt == s_r.postscale_select) begin
              s_nxt.post_cnt = 4'h0;
              s_nxt.pulse = 1'b1;
              flag_set = 1'b1;
            end else begin
              s_nxt.post_cnt = s_r.post_cnt + 4'h1;
            end
          end
        end else begin
          s_nxt.count_value = s_r.count_value + 8'h01;
        end
      end
    end
    if (flag_set) begin
      s_nxt.irq_flag = 1'b1;
    end

    // Data phase of a write; the address was captured one cycle earlier
    s_nxt.wr_pend = 1'b0;
    if (s_r.wr_pend) begin
      unique case (s_r.wr_addr)
        ptm_pkg::PTM_OFS_COUNT: begin
          s_nxt.count_value = hwdata[7:0];
          s_nxt.post_cnt = 4'h0;
        end
        ptm_pkg::PTM_OFS_PERIOD: s_nxt.period_value = hwdata[7:0];
        ptm_pkg::PTM_OFS_CONTROL: begin
          s_nxt.on = hwdata[ptm_pkg::PTM_CTRL_ON_BIT];
          s_nxt.postscale_select = hwdata[3:0];
          s_nxt.post_cnt = 4'h0;
        end
        ptm_pkg::PTM_OFS_LIMIT: begin
          s_nxt.mode = hwdata[4:0];
          // A start left over from the old mode must not carry into the new one
          s_nxt.started = 1'b0;
          s_nxt.src_fresh = 1'b1;
        end
        ptm_pkg::PTM_OFS_RESET_SOURCE_FIELD: begin
          s_nxt.reset_source_field = hwdata[3:0];
          s_nxt.started = 1'b0;
          s_nxt.src_fresh = 1'b1;
        end
        ptm_pkg::PTM_OFS_IRQ: begin
          // A match in the same cycle keeps the flag set
          if (hwdata[ptm_pkg::PTM_IRQ_FLAG_BIT] && !flag_set) begin
            s_nxt.irq_flag = 1'b0;
          end
          s_nxt.period_irq_enable = hwdata[ptm_pkg::PTM_IRQ_EN_BIT];
        end
        default: s_nxt.wr_pend = 1'b0;
      endcase
    end
    s_nxt.irq = s_nxt.irq_flag & s_nxt.period_irq_enable;

    // Zero-wait slave: read data is fetched at the address phase
    acc = hsel & htrans[1] & hready;
    s_nxt.hreadyout = 1'b1;
    s_nxt.hresp = 1'b0;
    if (acc) begin
      s_nxt.wr_pend = hwrite;
      s_nxt.wr_addr = haddr[7:0];
      s_nxt.hrdata = 32'h00000000;
      if (!hwrite) begin
        unique case (haddr[7:0])
          ptm_pkg::PTM_OFS_COUNT: s_nxt.hrdata = {24'h000000, s_r.count_value};
          ptm_pkg::PTM_OFS_PERIOD: s_nxt.hrdata = {24'h000000, s_r.period_value};
          ptm_pkg::PTM_OFS_CONTROL: s_nxt.hrdata = {24'h000000, s_r.on, 3'h0, s_r.postscale_select};
          ptm_pkg::PTM_OFS_LIMIT: s_nxt.hrdata = {27'h0, s_r.mode};
          ptm_pkg::PTM_OFS_RESET_SOURCE_FIELD: s_nxt.hrdata = {28'h0000000, s_r.reset_source_field};
          ptm_pkg::PTM_OFS_IRQ: s_nxt.hrdata = {30'h0, s_r.period_irq_enable, s_r.irq_flag};
          default: s_nxt.hrdata = 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_r <= '0;
      s_r.count_value <= ptm_pkg::PTM_RST_COUNT;
      s_r.period_value <= ptm_pkg::PTM_RST_PERIOD;
      s_r.hreadyout <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hrdata = s_r.hrdata;
  assign hresp = s_r.hresp;
  assign hreadyout = s_r.hreadyout;
  assign postscaled_pulse_out = s_r.pulse;
  assign irq_out = s_r.irq;
endmodule

//--- testbench/ptm_timer_checker.sv
/*
  Port assertions for ptm_timer.
  Assumes it is bound to every ptm_timer instance.
*/
`timescale 1ns/1ns
module ptm_timer_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic timer_tick,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic postscaled_pulse_out,
  input wire logic irq_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_ready_high: assert property (hreadyout == 1'b1) else $error("hreadyout low");
  a_resp_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
  a_reset_clears: assert property ($fell(sys_rst) |-> !postscaled_pulse_out && !irq_out && hrdata == 32'h0)
    else $error("outputs not cleared by reset");
  a_rdata_holds: assert property (!(hsel && htrans[1] && hready) |=> $stable(hrdata))
    else $error("hrdata moved without a request");
  a_unmapped_zero: assert property (hsel && htrans[1] && hready && !hwrite && haddr[7:0] > 8'h14 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_rdata_width: assert property (hsel && htrans[1] && hready && !hwrite |=> hrdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_pulse_on_tick: assert property (!timer_tick |=> $stable(postscaled_pulse_out))
    else $error("pulse changed off a tick");
  a_irq_cause: assert property ($rose(irq_out) |-> $past(timer_tick, 1) || ($past(htrans, 2) == 2'h2 && $past(hwrite, 2)))
    else $error("irq rose without tick or write");
endmodule
bind ptm_timer ptm_timer_checker i_ptm_timer_checker (.clk(clk), .sys_rst(sys_rst), .timer_tick(timer_tick),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .postscaled_pulse_out(postscaled_pulse_out), .irq_out(irq_out));

//--- testbench/ptm_src_model.sv
/*
  Neighbouring trigger sources of the timer.
  Assumes the bench changes code and level just after a clock edge.
*/
`timescale 1ns/1ns
module ptm_src_model (
  input wire logic clk,
  input wire logic [3:0] code,
  input wire logic lvl,
  output ptm_pkg::ptm_src_t src
);
  logic [10:0] v;
  // Unselected sources carry the inverse level so a wrong pick shows up
  always @(posedge clk) begin
    v = {11{~lvl}};
    if (code == 4'h0) v[10] = lvl;
    else if (code < 4'h4) v[4'h6 + code] = lvl;
    else if (code < 4'hB) v[4'hA - code] = lvl;
    src <= v;
  end
endmodule

//--- testbench/tb.sv
/*
  Self-checking bench for ptm_timer over AHB-Lite.
  Assumes one 25 MHz clock and a tick every second cycle.
*/
`timescale 1ns/1ns
module tb;
  logic clk, sys_rst, timer_tick, debug_mode, hsel, hwrite, lvl, hreadyout, hresp, postscaled_pulse_out, irq_out, pd;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] code;
  ptm_pkg::ptm_src_t src;
  int n_errors, checks_done, cyc, last, gap, hi, width, rises, r0, i;
  ptm_timer #(.INST_IDX(0)) i_ptm_timer (.clk(clk), .sys_rst(sys_rst), .timer_tick(timer_tick),
    .debug_mode(debug_mode), .src(src), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .postscaled_pulse_out(postscaled_pulse_out), .irq_out(irq_out));
  ptm_src_model i_ptm_src_model (.clk(clk), .code(code), .lvl(lvl), .src(src));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    timer_tick <= ~timer_tick;
    cyc <= cyc + 1;
    pd <= postscaled_pulse_out;
    hi <= postscaled_pulse_out ? hi + 1 : 0;
    if (postscaled_pulse_out && !pd) begin
      gap <= cyc - last;
      last <= cyc;
      rises <= rises + 1;
    end
    if (!postscaled_pulse_out && pd) width <= hi;
  end
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    xfer(a, 1'b0, 32'h0);
    chk(nm, e, q);
  endtask
  // Fifteen ticks per level: spacing and hold well above the minimum
  task automatic toggle();
    lvl <= ~lvl;
    repeat (30) @(posedge clk);
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #400000;
    n_errors++;
    report_and_stop();
  end
  initial begin
    {sys_rst, timer_tick, debug_mode, hsel, hwrite, lvl} = 6'h20;
    {haddr, hwdata, htrans, code} = 70'h0;
    hsize = 3'h2;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rd(8'h00, 32'h00, "count");
    rd(8'h04, 32'hFF, "period");
    rd(8'h18, 32'h00, "unmapped");
    xfer(8'h04, 1'b1, 32'h03);
    xfer(8'h14, 1'b1, 32'h02);
    xfer(8'h08, 1'b1, 32'h81);
    r0 = rises;
    for (i = 0; i < 200 && rises < r0 + 3; i++) @(posedge clk);
    chk("gap", 32'd16, gap);
    chk("width", 32'd2, width);
    rd(8'h14, 32'h03, "irq reg");
    chk("irq_out", 32'h1, {31'h0, irq_out});
    xfer(8'h08, 1'b1, 32'h00);
    xfer(8'h14, 1'b1, 32'h03);
    rd(8'h14, 32'h02, "irq cleared");
    xfer(8'h0C, 1'b1, 32'h08);
    r0 = rises;
    xfer(8'h08, 1'b1, 32'h83);
    q[7] = 1'b1;
    for (i = 0; i < 50 && q[7] !== 1'b0; i++) xfer(8'h08, 1'b0, 32'h0);
    repeat (40) @(posedge clk);
    chk("oneshot pulses", 32'd1, rises - r0);
    rd(8'h08, 32'h03, "oneshot control");
    rd(8'h00, 32'h00, "oneshot count");
    code <= 4'h6;
    xfer(8'h10, 1'b1, 32'h06);
    xfer(8'h0C, 1'b1, 32'h11);
    xfer(8'h08, 1'b1, 32'h80);
    r0 = rises;
    toggle();
    chk("mono first", 32'd1, rises - r0);
    rd(8'h08, 32'h80, "mono control");
    rd(8'h00, 32'h00, "mono count");
    toggle();
    toggle();
    chk("mono restart", 32'd2, rises - r0);
    debug_mode <= 1'b1;
    toggle();
    toggle();
    chk("debug edges", 32'd2, rises - r0);
    debug_mode <= 1'b0;
    xfer(8'h0C, 1'b1, 32'h01);
    xfer(8'h04, 1'b1, 32'hFF);
    for (i = 0; i < 11; i++) begin
      code <= i[3:0];
      lvl <= 1'b0;
      xfer(8'h10, 1'b1, i);
      xfer(8'h00, 1'b1, 32'h0);
      repeat (6) @(posedge clk);
      rd(8'h00, 32'h00, "gate low");
      lvl <= 1'b1;
      repeat (20) @(posedge clk);
      xfer(8'h00, 1'b0, 32'h0);
      chk("gate source", {31'h0, i != 1}, {31'h0, q != 32'h0});
    end
    report_and_stop();
  end
endmodule
